// ==== design/lpddr_pkg.sv ====
// Shared constants, timings and state codes for the self-refresh and
// mode-register-read device logic. Assumes a 20 MHz clk_sys.
package lpddr_pkg;

  // Mode register addresses
  localparam logic [7:0] MA_BANK_MASK = 8'h10;
  localparam logic [7:0] MA_SEG_MASK = 8'h11;

  // Values after reset (all banks and segments refresh-enabled), and read data for other addresses
  localparam logic [7:0] BANK_MASK_RST = 8'h00;
  localparam logic [7:0] SEG_MASK_RST = 8'h00;
  localparam logic [7:0] UNDEF_DATA = 8'h00;

  // Command field positions on CA: bank and low address bits on the rising half, op and top address bits on the falling half
  localparam int CA_BANK_LO = 7;
  localparam int CA_MA_LO = 4;
  localparam int CA_OP_LO = 2;

  // Times as printed or chosen, in ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int T_CKESR_NS = 15;
  localparam int T_XSR_NS = 140;
  localparam int T_RFCPB_NS = 60;
  localparam int T_RFCAB_NS = 130;
  localparam int T_REFI_NS = 7800;

  function automatic int ceil_cyc(input int ns);
    int c;
    c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  function automatic int floor_cyc(input int ns);
    int c;
    c = ns / CLK_PERIOD_NS;
    return (c < 1) ? 1 : c;
  endfunction

  // Cycle counts
  localparam int CKESR_CYC = ceil_cyc(T_CKESR_NS);
  localparam int TXSR_CYC = ceil_cyc(T_XSR_NS);
  localparam int RFCPB_CYC = ceil_cyc(T_RFCPB_NS);
  localparam int RFCAB_CYC = ceil_cyc(T_RFCAB_NS);
  localparam int REFI_CYC = floor_cyc(T_REFI_NS);
  localparam int TMRR_CYC = 2;
  localparam int MRR_BL = 4;

  typedef enum logic [2:0] {
    ST_ACTIVE = 3'b000,
    ST_SR_NOP = 3'b001,
    ST_SELF_REF = 3'b010,
    ST_SR_EXIT = 3'b011,
    ST_POWER_DOWN = 3'b100
  } dev_state_t;

endpackage

// ==== design/mrr_if.sv ====
// Carries a mode register read request from the command decoder to the
// burst generator. Both ends share clk_sys.
interface mrr_if;
  logic start;
  logic [7:0] data;
  logic busy;
  modport ctrl (output start, output data, input busy);
  modport burst (input start, input data, output busy);
endinterface

// ==== design/sr_tick_gen.sv ====
// Internal refresh interval timer used while in self-refresh.
// Assumes clk_sys runs on in self-refresh; it stands for the internal oscillator.
module sr_tick_gen #(
  parameter int PERIOD = lpddr_pkg::REFI_CYC,
  parameter int W = 12
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic en,
  output logic tick
);

  if (PERIOD < 1 || PERIOD >= (1 << W)) begin : g_bad
    $error("sr_tick_gen: PERIOD does not fit W");
  end

  localparam logic [W-1:0] LAST = W'(PERIOD - 1);

  logic [W-1:0] cnt_ff;
  logic [W-1:0] nxt_cnt;
  wire at_end = (cnt_ff == LAST);

  assign nxt_cnt = (!en || at_end) ? '0 : cnt_ff + W'(1);
  assign tick = en && at_end;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff <= '0;
    end else begin
      cnt_ff <= nxt_cnt;
    end
  end

endmodule

// ==== design/mrr_burst.sv ====
// Drives the four-beat mode register read burst on DQ and DQS.
// One beat per clk_sys cycle; the request comes over mrr_if.
module mrr_burst #(
  parameter int RL = 3,
  parameter int DQ_W = 16
) (
  input wire logic clk_sys,
  input wire logic rst,
  mrr_if.burst req,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic dqs_t_out,
  output logic dqs_c_out,
  output logic dqs_oe
);

  if (RL < 1 || RL > 8 || DQ_W < 8) begin : g_bad
    $error("mrr_burst: RL must be 1..8 and DQ_W at least 8");
  end

  localparam int LAST = RL + lpddr_pkg::MRR_BL;

  logic [3:0] cnt_ff;
  logic [7:0] data_ff;
  logic [DQ_W-1:0] dq_ff;
  logic oe_ff;
  logic dqs_ff;
  logic [3:0] nxt_cnt;
  wire in_burst = (cnt_ff >= 4'(RL)) && (cnt_ff < 4'(LAST));
  wire first_beat = (cnt_ff == 4'(RL));

  assign req.busy = (cnt_ff != 4'h0);
  assign nxt_cnt = req.start ? 4'h1 :
                   (cnt_ff == 4'(LAST)) ? 4'h0 :
                   (cnt_ff != 4'h0) ? cnt_ff + 4'h1 : 4'h0;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cnt_ff <= 4'h0;
      data_ff <= 8'h00;
      dq_ff <= '0;
      oe_ff <= 1'b0;
      dqs_ff <= 1'b0;
    end else begin
      cnt_ff <= nxt_cnt;
      if (req.start) begin
        data_ff <= req.data;
      end
      // Only the low byte of the first beat is defined
      dq_ff <= first_beat ? {{(DQ_W-8){1'b0}}, data_ff} : '0;
      oe_ff <= in_burst;
      // Strobe toggles on every beat of every burst
      dqs_ff <= in_burst ? ~dqs_ff : 1'b0;
    end
  end

  assign dq_out = dq_ff;
  assign dq_oe = oe_ff;
  assign dqs_t_out = dqs_ff;
  assign dqs_c_out = oe_ff ? ~dqs_ff : 1'b0;
  assign dqs_oe = oe_ff;

endmodule

// ==== design/lpddr_sr_device.sv ====
// Device-side command logic: self-refresh entry, residency and exit,
// power-down, partial-array masks, per-bank refresh and mode register read.
// Assumes CA rising and falling halves arrive together, synchronous to clk_sys.

// Contract
// - In self-refresh only CKE is heard; internal timer keeps data.
// - One all-bank refresh starts within minimum residency; internal clock gated.
// - Exit recovery counts from first rising edge with CKE high.
// - No refresh in power-down; controller bounds power-down duration.
// - Other banks accept operations during a per-bank refresh.
// - Eight-bit bank mask register at 10H written by mode register write.
// - Masked bank skips self-refresh; unmasked bank follows segment mask.
// - Segment mask at 11H blocks a segment in all enabled banks.
// - MRR is CA3..0 = 1000; address from CA1:0 falling, CA9:4 rising.
// - Register data on first beat of low byte lane after read latency.
// - Strobes toggle for every read burst, reserved registers included.
// - Read burst of four, uninterrupted; two-clock command period, NOPs only.
module lpddr_sr_device #(
  parameter int RL = 3,
  parameter int NBANK = 8,
  parameter int DQ_W = 16,
  parameter int REFI = lpddr_pkg::REFI_CYC
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [9:0] ca_r,
  input wire logic [9:0] ca_f,
  output logic [DQ_W-1:0] dq_out,
  output logic dq_oe,
  output logic dqs_t_out,
  output logic dqs_c_out,
  output logic dqs_oe,
  output logic sr_active,
  output logic int_clk_en,
  output logic refresh_pulse,
  output logic [7:0] refresh_bank_en,
  output logic [7:0] refresh_seg_en,
  output logic [NBANK-1:0] bank_busy,
  output logic act_accept,
  output logic cmd_ignored
);

  if (NBANK < 1 || NBANK > 8 || REFI < 1 || REFI > 4095) begin : g_bad
    $error("lpddr_sr_device: NBANK must be 1..8 and REFI 1..4095");
  end

  typedef enum logic [2:0] {
    CMD_NONE = 3'b000,
    CMD_MRW = 3'b001,
    CMD_MRR = 3'b010,
    CMD_REF = 3'b011,
    CMD_ACT = 3'b100,
    CMD_OTHER = 3'b101
  } cmd_t;

  // Rising-half command decode, shared by the entry and active paths
  function automatic cmd_t decode(input logic sel_n, input logic [9:0] c);
    cmd_t k;
    k = CMD_NONE;
    if (sel_n) begin
      k = CMD_NONE;
    end else if (c[2:0] == 3'b111) begin
      k = CMD_NONE;
    end else if (c[3:0] == 4'b0000) begin
      k = CMD_MRW;
    end else if (c[3:0] == 4'b1000) begin
      k = CMD_MRR;
    end else if (c[2:0] == 3'b100) begin
      k = CMD_REF;
    end else if (c[1:0] == 2'b10) begin
      k = CMD_ACT;
    end else begin
      k = CMD_OTHER;
    end
    return k;
  endfunction

  localparam logic [7:0] XSR_LAST = 8'(lpddr_pkg::TXSR_CYC - 1);
  localparam logic [7:0] CKESR_N = 8'(lpddr_pkg::CKESR_CYC);
  localparam logic [2:0] PB_LOAD = 3'(lpddr_pkg::RFCPB_CYC);
  localparam logic [2:0] AB_LOAD = 3'(lpddr_pkg::RFCAB_CYC);
  localparam logic [2:0] PTR_LAST = 3'(NBANK - 1);

  lpddr_pkg::dev_state_t state_ff;
  lpddr_pkg::dev_state_t nxt_state;
  logic cke_q_ff;
  logic [7:0] cnt_ff;
  logic [7:0] nxt_cnt;
  logic [7:0] bank_mask_ff;
  logic [7:0] seg_mask_ff;
  logic [2:0] pb_ptr_ff;
  logic refresh_pulse_ff;
  logic act_accept_ff;
  logic cmd_ignored_ff;
  logic sr_short_ff;
  logic sr_tick;

  mrr_if mrr ();

  // Decode
  wire cmd_t cmd = decode(cs_n, ca_r);
  wire [7:0] mr_addr = {ca_f[1:0], ca_r[9:lpddr_pkg::CA_MA_LO]};
  wire [7:0] mr_op = ca_f[9:lpddr_pkg::CA_OP_LO];
  wire [2:0] act_bank = ca_r[9:lpddr_pkg::CA_BANK_LO];
  wire ref_all = ca_r[3];

  wire cke_fall = cke_q_ff && !cke;
  wire sr_entry = cke_fall && (cmd == CMD_REF);
  wire pd_entry = cke_fall && !sr_entry;
  wire in_active = (state_ff == lpddr_pkg::ST_ACTIVE);
  wire live = in_active && cke && cke_q_ff;
  // The two-clock command period and the whole burst refuse commands
  wire cmd_seen = live && (cmd != CMD_NONE);
  wire mrr_blocked = mrr.busy;
  wire cmd_take = cmd_seen && !mrr_blocked;

  wire do_mrw = cmd_take && (cmd == CMD_MRW);
  wire do_mrr = cmd_take && (cmd == CMD_MRR);
  wire do_ref = cmd_take && (cmd == CMD_REF);
  wire do_refpb = do_ref && !ref_all;
  wire do_refab = do_ref && ref_all;
  wire act_seen = cmd_take && (cmd == CMD_ACT);
  wire act_bank_ok = (32'(act_bank) < NBANK);
  wire act_free = act_bank_ok && !bank_busy[act_bank[$clog2(NBANK > 1 ? NBANK : 2)-1:0]];
  wire act_ok = act_seen && act_free;

  wire wr_bank_mask = do_mrw && (mr_addr == lpddr_pkg::MA_BANK_MASK);
  wire wr_seg_mask = do_mrw && (mr_addr == lpddr_pkg::MA_SEG_MASK);

  // Reserved and write-only addresses answer with a defined level
  wire [7:0] mrr_data =
    (mr_addr == lpddr_pkg::MA_BANK_MASK) ? bank_mask_ff :
    (mr_addr == lpddr_pkg::MA_SEG_MASK) ? seg_mask_ff :
    lpddr_pkg::UNDEF_DATA;

  assign mrr.start = do_mrr;
  assign mrr.data = mrr_data;

  // Internal refresh requests come only from self-refresh states
  wire in_sr = (state_ff == lpddr_pkg::ST_SELF_REF);
  wire sr_first_ref = (state_ff == lpddr_pkg::ST_SR_NOP);
  wire nxt_refresh = sr_first_ref || (in_sr && sr_tick);

  // State and recovery counter
  always_comb begin
    nxt_state = state_ff;
    nxt_cnt = cnt_ff;
    case (state_ff)
      lpddr_pkg::ST_ACTIVE: begin
        if (sr_entry && !mrr_blocked) begin
          nxt_state = lpddr_pkg::ST_SR_NOP;
          nxt_cnt = 8'h01;
        end else if (pd_entry) begin
          nxt_state = lpddr_pkg::ST_POWER_DOWN;
        end
      end
      lpddr_pkg::ST_SR_NOP: begin
        // The cycle after entry carries a NOP and is not decoded
        nxt_state = lpddr_pkg::ST_SELF_REF;
        nxt_cnt = cnt_ff + 8'h01;
      end
      lpddr_pkg::ST_SELF_REF: begin
        // Only CKE is looked at here
        if (cke) begin
          nxt_state = lpddr_pkg::ST_SR_EXIT;
          // The exit edge itself is the first recovery cycle
          nxt_cnt = 8'h01;
        end else if (cnt_ff != 8'hff) begin
          nxt_cnt = cnt_ff + 8'h01;
        end
      end
      lpddr_pkg::ST_SR_EXIT: begin
        if (sr_entry) begin
          nxt_state = lpddr_pkg::ST_SR_NOP;
          nxt_cnt = 8'h01;
        end else if (cnt_ff >= XSR_LAST) begin
          nxt_state = lpddr_pkg::ST_ACTIVE;
          nxt_cnt = 8'h00;
        end else begin
          nxt_cnt = cnt_ff + 8'h01;
        end
      end
      lpddr_pkg::ST_POWER_DOWN: begin
        if (cke) begin
          nxt_state = lpddr_pkg::ST_ACTIVE;
        end
      end
      default: begin
        nxt_state = lpddr_pkg::ST_ACTIVE;
        nxt_cnt = 8'h00;
      end
    endcase
  end

  // An exit before the minimum residency is recorded, not refused
  wire early_exit = in_sr && cke && (cnt_ff < CKESR_N);

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      state_ff <= lpddr_pkg::ST_ACTIVE;
      cnt_ff <= 8'h00;
      cke_q_ff <= 1'b0;
    end else begin
      state_ff <= nxt_state;
      cnt_ff <= nxt_cnt;
      cke_q_ff <= cke;
    end
  end

  // Mask registers, written only outside any read burst
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      bank_mask_ff <= lpddr_pkg::BANK_MASK_RST;
      seg_mask_ff <= lpddr_pkg::SEG_MASK_RST;
    end else begin
      if (wr_bank_mask) begin
        bank_mask_ff <= mr_op;
      end
      if (wr_seg_mask) begin
        seg_mask_ff <= mr_op;
      end
    end
  end

  // Per-bank refresh walks the banks in order; all-bank resets the pointer
  wire [2:0] nxt_ptr = do_refab ? 3'h0 :
                       !do_refpb ? pb_ptr_ff :
                       (pb_ptr_ff == PTR_LAST) ? 3'h0 : pb_ptr_ff + 3'h1;

  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      pb_ptr_ff <= 3'h0;
    end else begin
      pb_ptr_ff <= nxt_ptr;
    end
  end

  // One busy timer per bank; only the bank under refresh is blocked
  for (genvar b = 0; b < NBANK; b++) begin : g_bank
    logic [2:0] busy_ff;
    wire hit_pb = do_refpb && (pb_ptr_ff == 3'(b));
    wire [2:0] nxt_busy = do_refab ? AB_LOAD :
                          hit_pb ? PB_LOAD :
                          (busy_ff != 3'h0) ? busy_ff - 3'h1 : 3'h0;
    always_ff @(posedge clk_sys or posedge rst) begin
      if (rst) begin
        busy_ff <= 3'h0;
      end else begin
        busy_ff <= nxt_busy;
      end
    end
    assign bank_busy[b] = (busy_ff != 3'h0);
  end

  // Pulses and status flags
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      refresh_pulse_ff <= 1'b0;
      act_accept_ff <= 1'b0;
      cmd_ignored_ff <= 1'b0;
      sr_short_ff <= 1'b0;
    end else begin
      refresh_pulse_ff <= nxt_refresh;
      act_accept_ff <= act_ok;
      cmd_ignored_ff <= (cmd_seen && mrr_blocked) || (act_seen && !act_free);
      sr_short_ff <= early_exit;
    end
  end

  sr_tick_gen #(
    .PERIOD(REFI),
    .W(12)
  ) u_tick (
    .clk_sys(clk_sys),
    .rst(rst),
    .en(in_sr),
    .tick(sr_tick)
  );

  mrr_burst #(
    .RL(RL),
    .DQ_W(DQ_W)
  ) u_mrr (
    .clk_sys(clk_sys),
    .rst(rst),
    .req(mrr.burst),
    .dq_out(dq_out),
    .dq_oe(dq_oe),
    .dqs_t_out(dqs_t_out),
    .dqs_c_out(dqs_c_out),
    .dqs_oe(dqs_oe)
  );

  // Set bit blocks refresh; banks beyond NBANK never refresh
  wire [7:0] bank_exist = 8'((9'h001 << NBANK) - 9'h001);
  assign refresh_bank_en = ~bank_mask_ff & bank_exist;
  assign refresh_seg_en = ~seg_mask_ff;

  assign sr_active = (state_ff == lpddr_pkg::ST_SR_NOP) || in_sr;
  // Gating the core clock is what saves power in self-refresh
  assign int_clk_en = !in_sr;
  assign refresh_pulse = refresh_pulse_ff;
  assign act_accept = act_accept_ff;
  assign cmd_ignored = cmd_ignored_ff || sr_short_ff;

endmodule

// ==== verification/lpddr_sr_asserts.sv ====
// Port-level assertions for lpddr_sr_device.
// Assumes binding to the device with its default DQ_W and NBANK.
module lpddr_sr_asserts #(
  parameter int RL = 3
) (
  input wire logic clk_sys,
  input wire logic rst,
  input wire logic cke,
  input wire logic cs_n,
  input wire logic [9:0] ca_r,
  input wire logic [9:0] ca_f,
  input wire logic [15:0] dq_out,
  input wire logic dq_oe,
  input wire logic dqs_t_out,
  input wire logic dqs_c_out,
  input wire logic sr_active,
  input wire logic int_clk_en,
  input wire logic refresh_pulse,
  input wire logic [7:0] refresh_bank_en,
  input wire logic [7:0] refresh_seg_en,
  input wire logic [7:0] bank_busy,
  input wire logic act_accept,
  input wire logic cmd_ignored
);
  localparam int BEAT0 = RL + 1;
  logic cke_ff;
  logic [3:0] rd_ff;
  logic [1:0] xsr_ff;
  // Tracks read-busy and exit recovery so only accepted commands are judged
  wire sel = cke && cke_ff && !cs_n;
  wire ok = sel && rd_ff == 4'h0 && xsr_ff == 2'h0 && !sr_active;
  wire [7:0] ma = {ca_f[1:0], ca_r[9:4]};
  wire mrw = ok && ca_r[3:0] == 4'h0;
  wire mrr = ok && ca_r[3:0] == 4'h8;
  wire act = ok && ca_r[1:0] == 2'h2;
  wire sx = cke && !cke_ff && sr_active;
  wire [3:0] nxt_rd = mrr ? 4'(RL + 4) : rd_ff - {3'h0, rd_ff != 4'h0};
  wire [1:0] nxt_xsr = sx ? 2'h2 : xsr_ff - {1'h0, xsr_ff != 2'h0};
  always_ff @(posedge clk_sys or posedge rst) begin
    if (rst) begin
      cke_ff <= 1'b0;
      rd_ff <= 4'h0;
      xsr_ff <= 2'h0;
    end else begin
      cke_ff <= cke;
      rd_ff <= nxt_rd;
      xsr_ff <= nxt_xsr;
    end
  end
  default clocking @(posedge clk_sys); endclocking
  default disable iff (rst);
  sequence sref_in;
    cke_ff && !cke && !cs_n && ca_r[2:0] == 3'h4 && !sr_active;
  endsequence
  sequence burst_s;
    (dq_oe && dqs_t_out && !dqs_c_out) ##1 (dq_oe && !dqs_t_out && dqs_c_out && dq_out == 16'h0)
    ##1 (dq_oe && dqs_t_out && dq_out == 16'h0) ##1 (dq_oe && !dqs_t_out && dq_out == 16'h0)
    ##1 !dq_oe;
  endsequence
  a_bank_mask_write: assert property (mrw && ma == 8'h10 |=> refresh_bank_en == ~$past(ca_f[9:2]))
    else $error("bank mask not applied");
  a_seg_mask_write: assert property (mrw && ma == 8'h11 |=> refresh_seg_en == ~$past(ca_f[9:2]))
    else $error("segment mask not applied");
  a_sref_enter: assert property (sref_in |=> sr_active ##1 (sr_active && !int_clk_en))
    else $error("self-refresh entry wrong");
  a_sref_refresh: assert property (sref_in |-> ##[1:2] refresh_pulse)
    else $error("no refresh after entry");
  a_sref_deaf: assert property (!int_clk_en |=> !act_accept && !dq_oe)
    else $error("command heard in self-refresh");
  a_sref_exit: assert property (sx |=> int_clk_en && !sr_active)
    else $error("exit not registered");
  a_pd_no_refresh: assert property (!sr_active && !$past(sr_active) |-> !refresh_pulse)
    else $error("refresh outside self-refresh");
  a_mrr_burst: assert property (mrr |-> ##BEAT0 burst_s)
    else $error("read burst wrong");
  a_busy_refuse: assert property (sel && rd_ff != 4'h0 && ca_r[2:0] != 3'h7 |=> cmd_ignored)
    else $error("command during read not refused");
  a_act_free: assert property (act && !bank_busy[ca_r[9:7]] |=> act_accept)
    else $error("activate to free bank refused");
  a_act_busy: assert property (act && bank_busy[ca_r[9:7]] |=> cmd_ignored && !act_accept)
    else $error("activate to busy bank taken");
endmodule
bind lpddr_sr_device lpddr_sr_asserts #(.RL(RL)) u_chk (.clk_sys(clk_sys), .rst(rst),
  .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f), .dq_out(dq_out), .dq_oe(dq_oe),
  .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out), .sr_active(sr_active),
  .int_clk_en(int_clk_en), .refresh_pulse(refresh_pulse), .refresh_bank_en(refresh_bank_en),
  .refresh_seg_en(refresh_seg_en), .bank_busy(bank_busy), .act_accept(act_accept),
  .cmd_ignored(cmd_ignored));

// ==== verification/lpddr_ctrl_model.sv ====
// Memory controller stand-in driving CKE, chip select and both CA halves.
// Assumes the bench calls its tasks; values change just after clk_sys rises.
module lpddr_ctrl_model (
  input wire logic clk_sys,
  output logic cke,
  output logic cs_n,
  output logic [9:0] ca_r,
  output logic [9:0] ca_f
);
  int seed = 58766;
  initial begin
    cke = 1'b0;
    cs_n = 1'b1;
    ca_r = 10'h3ff;
    ca_f = 10'h3ff;
  end
  task automatic drive(input logic c, input logic s, input logic [9:0] r, input logic [9:0] f);
    @(posedge clk_sys);
    cke <= c;
    cs_n <= s;
    ca_r <= r;
    ca_f <= f;
  endtask
  task automatic nop(input int n);
    repeat (n) begin
      drive(1'b1, 1'b0, {7'($random(seed)), 3'h7}, 10'($random(seed)));
    end
  endtask
  // A trailing NOP keeps the two-clock read command period clean
  task automatic cmd(input logic [9:0] r, input logic [9:0] f);
    drive(1'b1, 1'b0, r, f);
    nop(1);
  endtask
  // Caller leaves banks idle and refreshes all banks before entry
  task automatic sref_enter();
    drive(1'b0, 1'b0, 10'h004, 10'h3ff);
    drive(1'b0, 1'b0, 10'h3ff, 10'h3ff);
  endtask
  // Other lines are don't-care here, so they flip every cycle
  task automatic sref_stay(input int n);
    repeat (n) drive(1'b0, ~cs_n, ~ca_r, ~ca_f);
  endtask
  task automatic pd(input int n);
    repeat (n) drive(1'b0, 1'b1, 10'($random(seed)), 10'($random(seed)));
  endtask
endmodule

// ==== verification/sdram_self_refresh_and_mode_read_tb.sv ====
// Self-checking bench for lpddr_sr_device driven by the controller model.
// Assumes the checker binds itself; REFI is shortened to keep runs brief.
module sdram_self_refresh_and_mode_read_tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int RL = 3;
  localparam int REFI = 8;
  localparam int NBANK = 8;
  localparam int DQ_W = 16;
  logic clk_sys, rst, cke, cs_n, dq_oe, dqs_t_out, dqs_c_out, dqs_oe;
  logic sr_active, int_clk_en, refresh_pulse, act_accept, cmd_ignored;
  logic [9:0] ca_r, ca_f;
  logic [15:0] dq_out;
  logic [7:0] refresh_bank_en, refresh_seg_en, bank_busy, v, bank_exp, seg_exp;
  int n_fail = 0;
  int n_checks = 0;
  int seed = 58766;
  int cyc = 0;
  int cnt;
  lpddr_ctrl_model ctrl (.clk_sys(clk_sys), .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f));
  lpddr_sr_device #(.RL(RL), .NBANK(NBANK), .DQ_W(DQ_W), .REFI(REFI)) uut (.clk_sys(clk_sys),
    .rst(rst), .cke(cke), .cs_n(cs_n), .ca_r(ca_r), .ca_f(ca_f), .dq_out(dq_out),
    .dq_oe(dq_oe), .dqs_t_out(dqs_t_out), .dqs_c_out(dqs_c_out), .dqs_oe(dqs_oe),
    .sr_active(sr_active), .int_clk_en(int_clk_en), .refresh_pulse(refresh_pulse),
    .refresh_bank_en(refresh_bank_en), .refresh_seg_en(refresh_seg_en),
    .bank_busy(bank_busy), .act_accept(act_accept), .cmd_ignored(cmd_ignored));
  initial begin
    clk_sys = 1'b0;
    forever #25 clk_sys = ~clk_sys;
  end
  function automatic logic [15:0] beat(input int k);
    int b;
    b = k - RL;
    if (b < 0 || b > 3) return 16'h0;
    return {12'h0, 2'b11, ~b[0], b[0]};
  endfunction
  // Only the low lane of the first beat carries the register; upper lanes are free
  function automatic logic [15:0] exp_dq(input int k, input logic [7:0] ma);
    if (k != RL) return 16'h0;
    if (ma == 8'h10) return {8'h00, ~bank_exp};
    if (ma == 8'h11) return {8'h00, ~seg_exp};
    return {8'h00, lpddr_pkg::UNDEF_DATA};
  endfunction
  task automatic chk(input logic [15:0] got, input logic [15:0] exp, input string m);
    n_checks++;
    if (got !== exp) begin
      n_fail++;
      $display("mismatch at %0t: %s got %h exp %h", $time, m, got, exp);
    end
  endtask
  task automatic at(input int n);
    repeat (n) @(posedge clk_sys);
    @(negedge clk_sys);
  endtask
  task automatic mrw(input logic [7:0] ma, input logic [7:0] op);
    ctrl.cmd({ma[5:0], 4'h0}, {op, ma[7:6]});
  endtask
  task automatic summarize();
    $display("checks %0d mismatches %0d", n_checks, n_fail);
    if (n_fail == 0 && n_checks > 0) $display("bench passed");
    else $display("bench failed");
    $finish;
  endtask
  task automatic count_refresh(input int n);
    cnt = 0;
    repeat (n) begin
      @(negedge clk_sys);
      cnt += int'(refresh_pulse);
    end
  endtask
  always @(posedge clk_sys) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      n_fail++;
      summarize();
    end
  end
  initial begin
    rst = 1'b1;
    repeat (12) @(posedge clk_sys);
    rst <= 1'b0;
    at(0);
    chk({refresh_bank_en, refresh_seg_en}, 16'hffff, "reset masks");
    ctrl.nop(2);
    for (int i = 0; i < 6; i++) begin
      v = (i == 0) ? 8'h82 : 8'($random(seed));
      bank_exp = ~v;
      mrw(8'h10, v);
      at(1);
      chk(refresh_bank_en, bank_exp, "bank mask");
      v = (i == 0) ? 8'h84 : 8'($random(seed));
      seg_exp = ~v;
      mrw(8'h11, v);
      at(1);
      chk(refresh_seg_en, seg_exp, "segment mask");
    end
    $display("test masks done");
    for (int i = 0; i < 3; i++) begin
      v = (i == 0) ? 8'h10 : 8'($random(seed));
      ctrl.cmd({v[5:0], 4'h8}, {8'h00, v[7:6]});
      for (int k = 1; k <= RL + 5; k++) begin
        at(1);
        chk({dq_oe, dqs_oe, dqs_t_out, dqs_c_out}, beat(k), "strobes");
        chk(k == RL ? 16'(dq_out[7:0]) : dq_out, exp_dq(k, v), "beat data");
      end
    end
    ctrl.cmd({6'h10, 4'h8}, 10'h000);
    mrw(8'h10, 8'h5a);
    at(0);
    chk(cmd_ignored, 1'b1, "write during read");
    at(RL + 3);
    chk(refresh_bank_en, bank_exp, "mask kept");
    $display("test mode read done");
    ctrl.cmd(10'h00c, 10'h3ff);
    ctrl.nop(4);
    ctrl.sref_enter();
    fork
      ctrl.sref_stay(REFI + 4);
      count_refresh(REFI + 4);
    join
    chk(cnt, 2, "self-refresh pulses");
    at(0);
    chk({sr_active, int_clk_en}, 2'b10, "in self-refresh");
    ctrl.nop(1);
    mrw(8'h10, 8'hf0);
    mrw(8'h11, 8'h3c);
    at(1);
    chk({refresh_bank_en, refresh_seg_en}, {bank_exp, 8'hc3}, "exit recovery");
    chk({sr_active, int_clk_en}, 2'b01, "after exit");
    $display("test self-refresh done");
    fork
      ctrl.pd(2 * REFI);
      count_refresh(2 * REFI);
    join
    chk(cnt, 0, "power-down pulses");
    ctrl.nop(3);
    $display("test power-down done");
    ctrl.cmd(10'h00c, 10'h3ff);
    ctrl.nop(4);
    ctrl.drive(1'b1, 1'b0, 10'h004, 10'h3ff);
    ctrl.drive(1'b1, 1'b0, 10'h002, 10'h3ff);
    ctrl.drive(1'b1, 1'b0, 10'h182, 10'h3ff);
    at(0);
    chk({cmd_ignored, act_accept}, 2'b10, "busy bank");
    ctrl.nop(1);
    at(0);
    chk({cmd_ignored, act_accept}, 2'b01, "other bank");
    $display("test per-bank refresh done");
    summarize();
  end
endmodule
